// ===== inc/bridge_defs.svh
`ifndef BRIDGE_DEFS_SVH
`define BRIDGE_DEFS_SVH

// Register offsets on the serial control bus
`define ADDR_ANALOG_OFFSET      8'h41
`define ADDR_ANALOG_DATA        8'h42
`define ADDR_IBUS_CONTROL       8'h48
`define ADDR_IBUS_ADDRESS_LOW   8'h49
`define ADDR_IBUS_DATA_LOW      8'h4b
`define ADDR_VIDEO_INPUT_CTL    8'h4f

// Reset values
`define RESET_BYTE              8'h00

// Internal bus control fields
`define IBUS_ENABLE_BIT         0
`define IBUS_READ_BIT           1
`define IBUS_AUTOSTEP_BIT       2
`define IBUS_TARGET_LSB         3
`define IBUS_TARGET_MSB         4
`define IBUS_TARGET_CONFIG      2'h2
`define IBUS_TARGET_DIE_ID      2'h3

// Video input control fields
`define VID_MAP_SELECT_BIT      7
`define VID_INPUT_MODE_BIT      6
`define VID_PORT_SWAP_BIT       5

// Analog target select codes
`define ANALOG_SEL_OFF          3'h0
`define ANALOG_SEL_RECEIVER     3'h4
`define ANALOG_SEL_TRANSMITTER  3'h5

// Address step for both auto-increment modes
`define ADDRESS_STEP            8'h01

// Edges after reset release until synchronised straps are valid
`define STRAP_SETTLE_CYCLES     2'h2

`endif

// ===== inc/bridge_pkg.sv
package bridge_pkg;

   typedef logic [7:0] byte_t;

   typedef struct packed {
      logic  wr;
      logic  rd;
      byte_t addr;
      byte_t wdata;
   } reg_req_s;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [2:0] sel;
      byte_t      offset;
      byte_t      wdata;
   } analog_req_s;

   typedef struct packed {
      logic pixel_map_select;
      logic pixel_input_mode;
      logic input_port_swap;
      logic use_secondary_port;
      logic swap_ports;
   } video_cfg_s;

   typedef enum logic [2:0] {
      IBUS_IDLE    = 3'b001,
      IBUS_ISSUE   = 3'b010,
      IBUS_CAPTURE = 3'b100
   } ibus_state_e;

endpackage : bridge_pkg

// ===== design/strap_sync.sv
`timescale 1ns/1ps

module strap_sync (
   input  wire logic       ref_clk,
   input  wire logic       nrst,
   input  wire logic [1:0] strap_pin,
   output logic      [1:0] strap_sync
);

   logic [1:0] stage1_q;
   logic [1:0] stage2_q;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         stage1_q <= 2'h0;
         stage2_q <= 2'h0;
      end else begin
         stage1_q <= strap_pin;
         stage2_q <= stage1_q;
      end
   end

   assign strap_sync = stage2_q;

endmodule : strap_sync

// ===== design/config_store.sv
`timescale 1ns/1ps

module config_store (
   input  wire logic            ref_clk,
   input  wire logic            load_wr,
   input  wire bridge_pkg::byte_t load_addr,
   input  wire bridge_pkg::byte_t load_data,
   input  wire bridge_pkg::byte_t rd_addr,
   output bridge_pkg::byte_t     rd_data
);
   import bridge_pkg::*;

   byte_t mem [0:255];
   byte_t rd_data_q;

   // Registered read port, written only by the configuration loader
   always_ff @(posedge ref_clk) begin
      if (load_wr) begin
         mem[load_addr] <= load_data;
      end
      rd_data_q <= mem[rd_addr];
   end

   assign rd_data = rd_data_q;

endmodule : config_store

// ===== design/indirect_access_video_input_control.sv
// Notes on behaviour
// - 8-bit analog offset register, resets zero
// - Data write forwards byte to analog block when receiver or transmitter selected
// - Target 10 config, 11 die id, read only
// - Auto-increment adds one after internal access
// - Read bit launches read, self-clears on finish
// - Enable bit gates internal access interface
// - Internal address low byte, read-write, resets zero
// - Internal data low byte holds read result
// - Bit 7 selects pixel bit mapping
// - Mapping bit loaded from strap one
// - Bit 6 selects single or dual pixel
// - Input mode bit loaded from strap zero
// - Bit 5 secondary port or swap, reset zero
// - Analog select: off, receiver, transmitter codes
// - Analog auto-increment adds one per access
`timescale 1ns/1ps
`include "bridge_defs.svh"

module indirect_access_video_input_control #(
   parameter logic [63:0] DIE_ID = 64'h0123_4567_89ab_cdef // Arbitrary value
) (
   input  wire logic                    ref_clk,
   input  wire logic                    nrst,
   input  wire bridge_pkg::reg_req_s    reg_req,
   output bridge_pkg::byte_t            reg_rdata,
   output logic                         reg_rvalid,
   input  wire logic [2:0]              analog_target_select,
   input  wire logic                    analog_offset_autostep,
   output bridge_pkg::analog_req_s      analog_req,
   input  wire bridge_pkg::byte_t       analog_rdata,
   input  wire logic                    cfg_load_wr,
   input  wire bridge_pkg::byte_t       cfg_load_addr,
   input  wire bridge_pkg::byte_t       cfg_load_data,
   input  wire logic                    mode_strap_zero,
   input  wire logic                    mode_strap_one,
   output bridge_pkg::video_cfg_s       video_cfg
);
   import bridge_pkg::*;

   function automatic logic analog_target_ok(input logic [2:0] sel);
      analog_target_ok = (sel == `ANALOG_SEL_RECEIVER) ||
                         (sel == `ANALOG_SEL_TRANSMITTER);
   endfunction : analog_target_ok

   function automatic byte_t step_address(input byte_t addr,
                                          input logic  enable);
      step_address = enable ? 8'(addr + `ADDRESS_STEP) : addr;
   endfunction : step_address

   // Register state
   byte_t        analog_offset_q;
   byte_t        analog_offset_d;
   byte_t        analog_data_window_q;
   logic [1:0]   ibus_target_q;
   logic         ibus_autostep_q;
   logic         ibus_read_q;
   logic         ibus_enable_q;
   byte_t        internal_address_low_q;
   byte_t        internal_address_low_d;
   byte_t        internal_data_low_q;
   byte_t        internal_data_low_d;
   logic         pixel_map_select_q;
   logic         pixel_input_mode_q;
   logic         input_port_swap_q;
   logic [1:0]   settle_q;
   logic         straps_loaded_q;
   ibus_state_e  ibus_state_q;
   ibus_state_e  ibus_state_d;
   byte_t        die_byte_q;
   byte_t        reg_rdata_q;
   logic         reg_rvalid_q;
   analog_req_s  analog_req_q;
   video_cfg_s   video_cfg_q;

   // Synchronised straps and configuration store read data
   logic [1:0]   strap_synced;
   byte_t        cfg_rdata;

   strap_sync u_strap_sync (
      .ref_clk    (ref_clk),
      .nrst       (nrst),
      .strap_pin  ({mode_strap_one, mode_strap_zero}),
      .strap_sync (strap_synced)
   );

   config_store u_config_store (
      .ref_clk   (ref_clk),
      .load_wr   (cfg_load_wr),
      .load_addr (cfg_load_addr),
      .load_data (cfg_load_data),
      .rd_addr   (internal_address_low_q),
      .rd_data   (cfg_rdata)
   );

   // Address decode
   wire hit_analog_offset = reg_req.addr == `ADDR_ANALOG_OFFSET;
   wire hit_analog_data   = reg_req.addr == `ADDR_ANALOG_DATA;
   wire hit_ibus_control  = reg_req.addr == `ADDR_IBUS_CONTROL;
   wire hit_ibus_address  = reg_req.addr == `ADDR_IBUS_ADDRESS_LOW;
   wire hit_ibus_data     = reg_req.addr == `ADDR_IBUS_DATA_LOW;
   wire hit_video_ctl     = reg_req.addr == `ADDR_VIDEO_INPUT_CTL;

   wire wr_analog_offset = reg_req.wr && hit_analog_offset;
   wire wr_analog_data   = reg_req.wr && hit_analog_data;
   wire rd_analog_data   = reg_req.rd && hit_analog_data && !reg_req.wr;
   wire wr_ibus_control  = reg_req.wr && hit_ibus_control;
   wire wr_ibus_address  = reg_req.wr && hit_ibus_address;
   wire wr_ibus_data     = reg_req.wr && hit_ibus_data;
   wire wr_video_ctl     = reg_req.wr && hit_video_ctl
                           && straps_loaded_q;

   // Analog window access
   wire analog_live   = analog_target_ok(analog_target_select);
   wire analog_access = (wr_analog_data || rd_analog_data) && analog_live;

   always_comb begin
      analog_offset_d = analog_offset_q;
      if (wr_analog_offset) begin
         analog_offset_d = reg_req.wdata;
      end else if (analog_access) begin
         analog_offset_d = step_address(analog_offset_q,
                                        analog_offset_autostep);
      end
   end

   // Internal bus access
   wire ibus_target_ok = ibus_target_q[1];
   wire ibus_live      = ibus_enable_q && ibus_target_ok;
   wire ibus_start     = wr_ibus_control
                         && reg_req.wdata[`IBUS_READ_BIT]
                         && (ibus_state_q == IBUS_IDLE);
   wire ibus_read_done = ibus_state_q == IBUS_CAPTURE;
   wire ibus_data_wr   = wr_ibus_data && ibus_live;

   always_comb begin
      ibus_state_d = ibus_state_q;
      case (ibus_state_q)
         IBUS_IDLE: begin
            if (ibus_start) begin
               ibus_state_d = IBUS_ISSUE;
            end
         end
         IBUS_ISSUE: begin
            ibus_state_d = IBUS_CAPTURE;
         end
         IBUS_CAPTURE: begin
            ibus_state_d = IBUS_IDLE;
         end
         default: begin
            ibus_state_d = IBUS_IDLE;
         end
      endcase
   end

   // Targets are read only: a data write stores the byte unless a live read completes, and auto-steps the address when live
   always_comb begin
      internal_data_low_d = internal_data_low_q;
      if (ibus_read_done && ibus_live) begin
         internal_data_low_d = (ibus_target_q == `IBUS_TARGET_CONFIG)
                               ? cfg_rdata : die_byte_q;
      end else if (wr_ibus_data) begin
         internal_data_low_d = reg_req.wdata;
      end
   end

   always_comb begin
      internal_address_low_d = internal_address_low_q;
      if (wr_ibus_address) begin
         internal_address_low_d = reg_req.wdata;
      end else if ((ibus_read_done || ibus_data_wr) && ibus_live) begin
         internal_address_low_d = step_address(internal_address_low_q,
                                               ibus_autostep_q);
      end
   end

   // Read-back mux
   wire byte_t ibus_control_rd = {3'h0, ibus_target_q, ibus_autostep_q,
                                  ibus_read_q, ibus_enable_q};
   wire byte_t video_ctl_rd    = {pixel_map_select_q, pixel_input_mode_q,
                                  input_port_swap_q, 5'h00};
   wire byte_t read_mux =
      hit_analog_offset ? analog_offset_q :
      hit_analog_data   ? analog_rdata :
      hit_ibus_control  ? ibus_control_rd :
      hit_ibus_address  ? internal_address_low_q :
      hit_ibus_data     ? internal_data_low_q :
      hit_video_ctl     ? video_ctl_rd : `RESET_BYTE;

   // Port routing derived from mode and swap
   wire use_secondary = pixel_input_mode_q && input_port_swap_q;
   wire swap_ports    = !pixel_input_mode_q && input_port_swap_q;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         analog_offset_q      <= `RESET_BYTE;
         analog_data_window_q <= `RESET_BYTE;
      end else begin
         analog_offset_q <= analog_offset_d;
         if (wr_analog_data) begin
            analog_data_window_q <= reg_req.wdata;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         analog_req_q <= '0;
      end else begin
         analog_req_q.wr     <= wr_analog_data && analog_live;
         analog_req_q.rd     <= rd_analog_data && analog_live;
         analog_req_q.sel    <= analog_target_select;
         analog_req_q.offset <= analog_offset_d;
         analog_req_q.wdata  <= wr_analog_data ? reg_req.wdata
                                               : analog_data_window_q;
      end
   end

   // Request for a write carries the next offset, already stepped when auto-increment is on
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ibus_target_q   <= 2'h0;
         ibus_autostep_q <= 1'b0;
         ibus_enable_q   <= 1'b0;
      end else if (wr_ibus_control) begin
         ibus_target_q   <= reg_req.wdata[`IBUS_TARGET_MSB:`IBUS_TARGET_LSB];
         ibus_autostep_q <= reg_req.wdata[`IBUS_AUTOSTEP_BIT];
         ibus_enable_q   <= reg_req.wdata[`IBUS_ENABLE_BIT];
      end
   end

   // Set on start wins; hardware clears it on completion
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ibus_read_q <= 1'b0;
      end else if (ibus_start) begin
         ibus_read_q <= 1'b1;
      end else if (ibus_read_done) begin
         ibus_read_q <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ibus_state_q           <= IBUS_IDLE;
         internal_address_low_q <= `RESET_BYTE;
         internal_data_low_q    <= `RESET_BYTE;
         die_byte_q             <= `RESET_BYTE;
      end else begin
         ibus_state_q           <= ibus_state_d;
         internal_address_low_q <= internal_address_low_d;
         internal_data_low_q    <= internal_data_low_d;
         die_byte_q             <= DIE_ID[{internal_address_low_q[2:0],
                                           3'h0} +: 8];
      end
   end

   // Strap capture once the synchroniser has settled
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         settle_q        <= 2'h0;
         straps_loaded_q <= 1'b0;
      end else begin
         if (settle_q != `STRAP_SETTLE_CYCLES) begin
            settle_q <= 2'(settle_q + 2'h1);
         end else begin
            straps_loaded_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         pixel_map_select_q <= 1'b0;
         pixel_input_mode_q <= 1'b0;
         input_port_swap_q  <= 1'b0;
      end else if (!straps_loaded_q) begin
         pixel_map_select_q <= strap_synced[1];
         pixel_input_mode_q <= strap_synced[0];
      end else if (wr_video_ctl) begin
         pixel_map_select_q <= reg_req.wdata[`VID_MAP_SELECT_BIT];
         pixel_input_mode_q <= reg_req.wdata[`VID_INPUT_MODE_BIT];
         input_port_swap_q  <= reg_req.wdata[`VID_PORT_SWAP_BIT];
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         video_cfg_q <= '0;
      end else begin
         video_cfg_q.pixel_map_select   <= pixel_map_select_q;
         video_cfg_q.pixel_input_mode   <= pixel_input_mode_q;
         video_cfg_q.input_port_swap    <= input_port_swap_q;
         video_cfg_q.use_secondary_port <= use_secondary;
         video_cfg_q.swap_ports         <= swap_ports;
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         reg_rdata_q  <= `RESET_BYTE;
         reg_rvalid_q <= 1'b0;
      end else begin
         reg_rvalid_q <= reg_req.rd && !reg_req.wr;
         if (reg_req.rd && !reg_req.wr) begin
            reg_rdata_q <= read_mux;
         end
      end
   end

   assign reg_rdata  = reg_rdata_q;
   assign reg_rvalid = reg_rvalid_q;
   assign analog_req = analog_req_q;
   assign video_cfg  = video_cfg_q;

endmodule : indirect_access_video_input_control

// ===== verif/video_input_control_asserts.sv
`timescale 1ns/1ps

module video_input_control_asserts (
   input wire logic                    ref_clk,
   input wire logic                    nrst,
   input wire bridge_pkg::reg_req_s    reg_req,
   input wire bridge_pkg::byte_t       reg_rdata,
   input wire logic                    reg_rvalid,
   input wire logic [2:0]              analog_target_select,
   input wire logic                    analog_offset_autostep,
   input wire bridge_pkg::analog_req_s analog_req,
   input wire bridge_pkg::byte_t       analog_rdata,
   input wire bridge_pkg::video_cfg_s  video_cfg
);
   import bridge_pkg::*;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);

   wire rd_only  = reg_req.rd && !reg_req.wr;
   wire live_sel = analog_target_select inside {3'h4, 3'h5};
   wire wr_data  = reg_req.wr && reg_req.addr == 8'h42;
   wire rd_data  = rd_only && reg_req.addr == 8'h42;
   wire touch    = (reg_req.wr || reg_req.rd)
                   && reg_req.addr inside {8'h41, 8'h42};

   read_answer_a: assert property (1 |=> reg_rvalid == $past(rd_only))
      else $error("read answer pulse wrong");
   analog_fwd_a: assert property (wr_data && live_sel |=> analog_req.wr
      && analog_req.wdata == $past(reg_req.wdata))
      else $error("analog write not forwarded");
   analog_off_a: assert property (wr_data && !live_sel |=> !analog_req.wr)
      else $error("analog write forwarded while off");
   offset_step_a: assert property (wr_data && live_sel
      && analog_offset_autostep
      |=> analog_req.offset == $past(analog_req.offset) + 8'h01)
      else $error("analog offset did not step");
   offset_hold_a: assert property (!touch |=> $stable(analog_req.offset))
      else $error("analog offset moved");
   offset_load_a: assert property (reg_req.wr && reg_req.addr == 8'h41
      ##1 !touch |=> analog_req.offset == $past(reg_req.wdata, 2))
      else $error("analog offset not loaded");
   analog_read_a: assert property (rd_data && live_sel
      |=> reg_rdata == $past(analog_rdata))
      else $error("analog read data wrong");
   video_rsvd_a: assert property (rd_only && reg_req.addr == 8'h4f
      |=> reg_rdata[4:0] == 5'h00)
      else $error("reserved video bits not zero");
   secondary_port_a: assert property (video_cfg.use_secondary_port
      == (video_cfg.pixel_input_mode && video_cfg.input_port_swap))
      else $error("secondary port select wrong");
   port_swap_a: assert property (video_cfg.swap_ports
      == (!video_cfg.pixel_input_mode && video_cfg.input_port_swap))
      else $error("port swap wrong");

   cover property (wr_data && live_sel && analog_offset_autostep);
   cover property (rd_data && live_sel);
   cover property (video_cfg.swap_ports);
endmodule : video_input_control_asserts

bind indirect_access_video_input_control video_input_control_asserts u_asserts (
   .ref_clk(ref_clk), .nrst(nrst), .reg_req(reg_req),
   .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
   .analog_target_select(analog_target_select),
   .analog_offset_autostep(analog_offset_autostep),
   .analog_req(analog_req), .analog_rdata(analog_rdata),
   .video_cfg(video_cfg));

// ===== verif/test_indirect_access_video_input_control.sv
`timescale 1ns/1ps

module test_indirect_access_video_input_control;
   import bridge_pkg::*;

   logic        ref_clk;
   logic        nrst;
   reg_req_s    reg_req;
   byte_t       reg_rdata;
   logic        reg_rvalid;
   logic [2:0]  analog_target_select;
   logic        analog_offset_autostep;
   analog_req_s analog_req;
   byte_t       analog_rdata;
   logic        cfg_load_wr;
   byte_t       cfg_load_addr;
   byte_t       cfg_load_data;
   logic        mode_strap_zero;
   logic        mode_strap_one;
   video_cfg_s  video_cfg;
   int          n_fail;
   int          num_checks;
   int          cycles;
   byte_t       inc;
   byte_t       rst_addr[6] = '{8'h41, 8'h48, 8'h49, 8'h4b, 8'h00, 8'h4a};
   logic [2:0]  codes[5] = '{3'h4, 3'h5, 3'h0, 3'h6, 3'h4};
   logic        steps[5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};

   // Die code value is arbitrary
   indirect_access_video_input_control #(.DIE_ID(64'h3c3c_3c3c_3c3c_3c3c)) dut (
      .ref_clk(ref_clk), .nrst(nrst), .reg_req(reg_req),
      .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .analog_target_select(analog_target_select),
      .analog_offset_autostep(analog_offset_autostep),
      .analog_req(analog_req), .analog_rdata(analog_rdata),
      .cfg_load_wr(cfg_load_wr), .cfg_load_addr(cfg_load_addr),
      .cfg_load_data(cfg_load_data), .mode_strap_zero(mode_strap_zero),
      .mode_strap_one(mode_strap_one), .video_cfg(video_cfg));

   // Analog block content follows its offset
   assign analog_rdata = analog_req.offset ^ 8'h3c;

   task automatic close_out;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : close_out

   task automatic chk(input byte_t got, input byte_t exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk

   task automatic chk_v(input video_cfg_s got, input video_cfg_s exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: video %b want %b", $time, got, exp);
      end
   endtask : chk_v

   task automatic reg_wr(input byte_t a, input byte_t d);
      reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge ref_clk);
      #1 reg_req.wr = 1'b0;
      @(posedge ref_clk);
      #1;
   endtask : reg_wr

   task automatic reg_rd(input byte_t a, input byte_t exp);
      reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge ref_clk);
      #1 reg_req.rd = 1'b0;
      // Answer stands for one cycle only, right after the read edge
      chk(reg_rvalid === 1'b1 ? reg_rdata : ~exp, exp);
      @(posedge ref_clk);
      #1;
   endtask : reg_rd

   // Start an internal read and wait for its completion edge
   task automatic ibus_go(input byte_t ctl);
      reg_wr(8'h48, ctl);
      @(posedge ref_clk);
      #1;
   endtask : ibus_go

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 3000) begin
         n_fail++;
         $display("unexpected at %0t: run timed out", $time);
         close_out();
      end
   end

   initial begin
      nrst = 1'b0;
      reg_req = '0;
      analog_target_select = 3'h0;
      analog_offset_autostep = 1'b0;
      cfg_load_wr = 1'b0;
      cfg_load_addr = 8'h00;
      cfg_load_data = 8'h00;
      mode_strap_zero = 1'b1;
      mode_strap_one = 1'b0;
      repeat (8) @(posedge ref_clk);
      #1 nrst = 1'b1;
      repeat (6) @(posedge ref_clk);
      #1;
      foreach (rst_addr[i]) reg_rd(rst_addr[i], 8'h00);
      reg_rd(8'h4f, 8'h40);
      chk_v(video_cfg, 5'b01000);
      reg_wr(8'h4f, 8'hff);
      reg_rd(8'h4f, 8'he0);
      chk_v(video_cfg, 5'b11110);
      reg_wr(8'h4f, 8'h20);
      reg_rd(8'h4f, 8'h20);
      chk_v(video_cfg, 5'b00101);
      reg_wr(8'h4a, 8'hff);
      reg_rd(8'h4a, 8'h00);
      for (int i = 0; i < 5; i++) begin
         analog_target_select = codes[i];
         analog_offset_autostep = steps[i];
         inc = (codes[i] inside {3'h4, 3'h5} && steps[i]) ? 8'h01 : 8'h00;
         @(posedge ref_clk);
         #1;
         reg_wr(8'h41, 8'h05);
         reg_wr(8'h42, 8'ha5);
         reg_rd(8'h41, 8'h05 + inc);
         if (codes[i] inside {3'h4, 3'h5}) begin
            reg_rd(8'h42, (8'h05 + inc) ^ 8'h3c);
            reg_rd(8'h41, 8'h05 + inc + inc);
         end
      end
      cfg_load_wr = 1'b1;
      for (int j = 0; j < 2; j++) begin
         cfg_load_addr = 8'h10 + 8'(j);
         cfg_load_data = 8'h5a + 8'(j);
         @(posedge ref_clk);
         #1;
      end
      cfg_load_wr = 1'b0;
      reg_wr(8'h49, 8'h10);
      ibus_go(8'h17);
      reg_rd(8'h48, 8'h15);
      reg_rd(8'h4b, 8'h5a);
      reg_rd(8'h49, 8'h11);
      ibus_go(8'h17);
      reg_rd(8'h4b, 8'h5b);
      reg_rd(8'h49, 8'h12);
      reg_wr(8'h49, 8'h10);
      ibus_go(8'h16);
      reg_rd(8'h4b, 8'h5b);
      reg_rd(8'h49, 8'h10);
      ibus_go(8'h0f);
      reg_rd(8'h4b, 8'h5b);
      reg_wr(8'h49, 8'h03);
      ibus_go(8'h1f);
      reg_rd(8'h4b, 8'h3c);
      reg_rd(8'h49, 8'h04);
      reg_wr(8'h48, 8'he0);
      reg_rd(8'h48, 8'h00);
      reg_wr(8'h4b, 8'h77);
      reg_rd(8'h4b, 8'h77);
      close_out();
   end
endmodule : test_indirect_access_video_input_control
